// *** dv/adc_diag_chop_delay_ctrl_assertions.sv ***
`timescale 1ns/100ps
`default_nettype none

module adc_ctrl_checker (
  input wire logic                           aclk,
  input wire logic                           aresetn,
  input wire adc_ctrl_pkg::axil_req_s        axil_req,
  input wire adc_ctrl_pkg::axil_rsp_s        axil_rsp,
  input wire adc_ctrl_pkg::diag_kind_e [3:0] chan_diag_kind,
  input wire logic [3:0]                     chan_mod_clk_delay,
  input wire logic [3:0][1:0]                chan_chop_rate
);
  default clocking @(posedge aclk); endclocking
  default disable iff (!aresetn);
  ////////////////////////////////////////////////////////////////
  property p_rst_out;
    $rose(aresetn) |-> chan_chop_rate == 8'hAA && chan_mod_clk_delay == 4'h0 && chan_diag_kind == 8'h00;
  endproperty
  a_rst_out: assert property (p_rst_out) else $error("outputs wrong after reset");
  property p_dly_pair;
    chan_mod_clk_delay[1] == chan_mod_clk_delay[0] && chan_mod_clk_delay[3] == chan_mod_clk_delay[2];
  endproperty
  a_dly_pair: assert property (p_dly_pair) else $error("delay pairs differ");
  property p_dly_chg; $changed(chan_mod_clk_delay) |-> $past(axil_rsp.bvalid); endproperty
  a_dly_chg: assert property (p_dly_chg) else $error("delay changed without write");
  property p_diag_chg; $changed(chan_diag_kind) |-> $past(axil_rsp.bvalid); endproperty
  a_diag_chg: assert property (p_diag_chg) else $error("diag changed without write");
  property p_chop_chg; $changed(chan_chop_rate) |-> $past(axil_rsp.bvalid); endproperty
  a_chop_chg: assert property (p_chop_chg) else $error("chop changed without write");
  property p_rd_hi; axil_rsp.rvalid |-> axil_rsp.rdata[31:8] == 24'h0; endproperty
  a_rd_hi: assert property (p_rd_hi) else $error("upper read bits set");
  property p_err_zero;
    axil_rsp.rvalid && axil_rsp.rresp == adc_ctrl_pkg::RESP_SLVERR |-> axil_rsp.rdata == 32'h0;
  endproperty
  a_err_zero: assert property (p_err_zero) else $error("error read not zero");
  property p_b_time;
    axil_req.awvalid && axil_rsp.awready && axil_req.wvalid && axil_rsp.wready |=> ##1 axil_rsp.bvalid;
  endproperty
  a_b_time: assert property (p_b_time) else $error("write response late");
  property p_r_time;
    axil_req.arvalid && axil_rsp.arready |=> axil_rsp.rvalid;
  endproperty
  a_r_time: assert property (p_r_time) else $error("read answer late");
  c_write: cover property (axil_req.awvalid && axil_rsp.awready);
  c_slverr: cover property (axil_rsp.rvalid && axil_rsp.rresp == adc_ctrl_pkg::RESP_SLVERR);
  c_dly_all: cover property (chan_mod_clk_delay == 4'hF);
endmodule : adc_ctrl_checker

bind adc_diag_chop_delay_ctrl adc_ctrl_checker i_chk (.aclk, .aresetn, .axil_req, .axil_rsp,
  .chan_diag_kind, .chan_mod_clk_delay, .chan_chop_rate);

`default_nettype wire

// *** dv/test_adc_diag_chop_delay_ctrl.sv ***
`timescale 1ns/100ps
`default_nettype none

module test_adc_diag_chop_delay_ctrl;
  logic                           aclk;
  logic                           aresetn;
  adc_ctrl_pkg::axil_req_s        axil_req;
  adc_ctrl_pkg::axil_rsp_s        axil_rsp;
  adc_ctrl_pkg::diag_kind_e [3:0] chan_diag_kind;
  logic [3:0]                     chan_mod_clk_delay;
  logic [3:0][1:0]                chan_chop_rate;
  int                             mismatches = 0;
  int                             cmp_count = 0;
  int                             cyc = 0;
  adc_diag_chop_delay_ctrl i_dut (.aclk, .aresetn, .axil_req, .axil_rsp, .chan_diag_kind,
    .chan_mod_clk_delay, .chan_chop_rate);
  ////////////////////////////////////////////////////////////////
  initial begin
    aclk = 1'b0;
    forever #20 aclk = ~aclk;
  end
  always @(posedge aclk) begin
    cyc <= cyc + 1;
    if (cyc == 3000) begin
      mismatches++;
      wrap_up();
    end
  end
  ////////////////////////////////////////////////////////////////
  task automatic wrap_up();
    $display("compares %0d mismatches %0d", cmp_count, mismatches);
    if (mismatches == 0 && cmp_count > 0) begin
      $display("TB: PASS");
    end else begin
      $display("TB: FAIL");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    cmp_count++;
    if (g !== e) begin
      mismatches++;
      $display("[ERR] %0t got %h exp %h", $time, g, e);
    end
  endtask : chk
  function automatic logic [1:0] kind(input logic [2:0] c);
    return (c == 3'h3) ? 2'h1 : (c == 3'h4) ? 2'h2 : (c == 3'h5) ? 2'h3 : 2'h0;
  endfunction : kind
  task automatic wr(input logic [11:0] a, input logic [7:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic ad, wd, ta, tw, b;
    logic [1:0] r;
    {ad, wd, b} = 3'h0;
    axil_req.awaddr <= a;
    axil_req.wdata <= {24'h0, d};
    axil_req.wstrb <= s;
    {axil_req.awvalid, axil_req.wvalid, axil_req.bready} <= 3'h7;
    while (!(ad && wd)) begin
      @(negedge aclk);
      {ta, tw} = {axil_rsp.awready & ~ad, axil_rsp.wready & ~wd};
      @(posedge aclk);
      if (ta) begin
        ad = 1'b1;
        axil_req.awvalid <= 1'b0;
      end
      if (tw) begin
        wd = 1'b1;
        axil_req.wvalid <= 1'b0;
      end
    end
    while (!b) begin
      @(negedge aclk);
      {b, r} = {axil_rsp.bvalid, axil_rsp.bresp};
      @(posedge aclk);
    end
    axil_req.bready <= 1'b0;
    @(posedge aclk);
    chk({30'h0, r}, {30'h0, er});
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [7:0] e, input logic [1:0] er);
    logic t;
    logic [31:0] d;
    logic [1:0] r;
    t = 1'b0;
    axil_req.araddr <= a;
    {axil_req.arvalid, axil_req.rready} <= 2'h3;
    while (!t) begin
      @(negedge aclk);
      t = axil_rsp.arready;
      @(posedge aclk);
    end
    axil_req.arvalid <= 1'b0;
    t = 1'b0;
    while (!t) begin
      @(negedge aclk);
      {t, d, r} = {axil_rsp.rvalid, axil_rsp.rdata, axil_rsp.rresp};
      @(posedge aclk);
    end
    axil_req.rready <= 1'b0;
    @(posedge aclk);
    chk(d, {24'h0, e});
    chk({30'h0, r}, {30'h0, er});
  endtask : rd
  ////////////////////////////////////////////////////////////////
  initial begin
    axil_req = '0;
    aresetn = 1'b0;
    repeat (5) @(posedge aclk);
    aresetn <= 1'b1;
    @(posedge aclk);
    rd(adc_ctrl_pkg::ADDR_DIAG_VOLTAGE_SEL, 8'h00, 2'h0);
    rd(adc_ctrl_pkg::ADDR_MOD_CLK_DELAY, 8'h02, 2'h0);
    rd(adc_ctrl_pkg::ADDR_CHOP_RATE, 8'h0A, 2'h0);
    chk({24'h0, chan_chop_rate}, 32'h0000_00AA);
    $display("test reset done");
    wr(adc_ctrl_pkg::ADDR_CHAN_GROUP_MAP, 8'h0A, 4'hF, 2'h0);
    rd(adc_ctrl_pkg::ADDR_CHAN_GROUP_MAP, 8'h0A, 2'h0);
    for (int i = 0; i < 8; i++) begin
      wr(adc_ctrl_pkg::ADDR_DIAG_VOLTAGE_SEL, {1'b1, 3'(7 - i), 1'b1, 3'(i)}, 4'hF, 2'h0);
      rd(adc_ctrl_pkg::ADDR_DIAG_VOLTAGE_SEL, {1'b0, 3'(7 - i), 1'b0, 3'(i)}, 2'h0);
      chk({24'h0, chan_diag_kind}, {24'h0, {2{kind(3'(7 - i)), kind(3'(i))}}});
      rd(adc_ctrl_pkg::ADDR_CHAN_STATUS, {2{kind(3'(7 - i)), kind(3'(i))}}, 2'h0);
    end
    $display("test diag done");
    for (int k = 0; k < 4; k++) begin
      wr(adc_ctrl_pkg::ADDR_MOD_CLK_DELAY, {4'h0, 2'(k), 2'h2}, 4'hF, 2'h0);
      rd(adc_ctrl_pkg::ADDR_MOD_CLK_DELAY, {4'h0, 2'(k), 2'h2}, 2'h0);
      chk({28'h0, {2{k[1]}}, {2{k[0]}}}, {28'h0, chan_mod_clk_delay});
      wr(adc_ctrl_pkg::ADDR_CHOP_RATE, {4'h0, 2'(k), 2'(3 - k)}, 4'hF, 2'h0);
      rd(adc_ctrl_pkg::ADDR_CHOP_RATE, {4'h0, 2'(k), 2'(3 - k)}, 2'h0);
      chk({24'h0, chan_chop_rate}, {24'h0, {2{2'(3 - k), 2'(k)}}});
    end
    $display("test delay chop done");
    wr(12'h100, 8'h55, 4'hF, adc_ctrl_pkg::RESP_SLVERR);
    rd(12'h100, 8'h00, adc_ctrl_pkg::RESP_SLVERR);
    wr(adc_ctrl_pkg::ADDR_CHOP_RATE, 8'h05, 4'h0, 2'h0);
    rd(adc_ctrl_pkg::ADDR_CHOP_RATE, 8'h0C, 2'h0);
    $display("test refusal done");
    wrap_up();
  end
endmodule : test_adc_diag_chop_delay_ctrl

`default_nettype wire

// *** logic/adc_ctrl_pkg.sv ***
package adc_ctrl_pkg;

  localparam int unsigned ADDR_W   = 12;
  localparam int unsigned NUM_CHAN = 4;

  // register indices; byte address is four times the index
  localparam logic [7:0] IDX_CHAN_GROUP_MAP   = 8'h03;
  localparam logic [7:0] IDX_DIAG_VOLTAGE_SEL = 8'h57;
  localparam logic [7:0] IDX_MOD_CLK_DELAY    = 8'h58;
  localparam logic [7:0] IDX_CHOP_RATE        = 8'h59;
  localparam logic [7:0] IDX_CHAN_STATUS      = 8'h5A;

  localparam logic [ADDR_W-1:0] ADDR_CHAN_GROUP_MAP   = {2'h0, IDX_CHAN_GROUP_MAP, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_DIAG_VOLTAGE_SEL = {2'h0, IDX_DIAG_VOLTAGE_SEL, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_MOD_CLK_DELAY    = {2'h0, IDX_MOD_CLK_DELAY, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CHOP_RATE        = {2'h0, IDX_CHOP_RATE, 2'h0};
  localparam logic [ADDR_W-1:0] ADDR_CHAN_STATUS      = {2'h0, IDX_CHAN_STATUS, 2'h0};

  // reset values
  localparam logic [3:0] RST_CHAN_GROUP_MAP   = 4'h0;
  localparam logic [7:0] RST_DIAG_VOLTAGE_SEL = 8'h00;
  localparam logic [3:0] RST_MOD_CLK_DELAY    = 4'h2;
  localparam logic [3:0] RST_CHOP_RATE        = 4'hA;

  // field positions
  localparam int unsigned FIRST_DIAG_LSB   = 0;
  localparam int unsigned SECOND_DIAG_LSB  = 4;
  localparam int unsigned DELAY_PAIRS_LSB  = 2;
  localparam int unsigned DELAY_RSVD_LSB   = 0;
  localparam int unsigned FIRST_CHOP_LSB   = 2;
  localparam int unsigned SECOND_CHOP_LSB  = 0;

  // diagnostic selector codes
  localparam logic [2:0] DIAG_SEL_OFF  = 3'h0;
  localparam logic [2:0] DIAG_SEL_POS  = 3'h3;
  localparam logic [2:0] DIAG_SEL_NEG  = 3'h4;
  localparam logic [2:0] DIAG_SEL_ZERO = 3'h5;

  // chop rate codes
  localparam logic [1:0] CHOP_DIV8  = 2'h1;
  localparam logic [1:0] CHOP_DIV32 = 2'h2;

  localparam logic [1:0] RESP_OKAY   = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  typedef enum logic [1:0] {
    DIAG_NONE = 2'b00,
    DIAG_POS  = 2'b01,
    DIAG_NEG  = 2'b10,
    DIAG_ZERO = 2'b11
  } diag_kind_e;

  typedef struct packed {
    logic              awvalid;
    logic [ADDR_W-1:0] awaddr;
    logic              wvalid;
    logic [31:0]       wdata;
    logic [3:0]        wstrb;
    logic              bready;
    logic              arvalid;
    logic [ADDR_W-1:0] araddr;
    logic              rready;
  } axil_req_s;

  typedef struct packed {
    logic        awready;
    logic        wready;
    logic        bvalid;
    logic [1:0]  bresp;
    logic        arready;
    logic        rvalid;
    logic [31:0] rdata;
    logic [1:0]  rresp;
  } axil_rsp_s;

endpackage : adc_ctrl_pkg

// *** logic/adc_diag_chop_delay_ctrl.sv ***
// Overview of operation
// [RULE1] diag select: group A bits 2:0, B 6:4
// [RULE2] codes 000 off, 011 pos, 100 neg, 101 zero
// [RULE3] route group selection per channel group map
// [RULE4] software enables receivers before selecting voltages
// [RULE5] delay field: 00 none, 01 ch0-1, 10 ch2-3, 11 all
// [RULE6] software writes 10 to reserved delay bits
// [RULE7] chop A bits 3:2, B 1:0; 01 is /8
// [RULE8] chop code 10 is /32; reset 0x0A
// [RULE9] diagnostic needs receive enable and precharge buffers
// [RULE10] undefined codes mean off; undefined bits read zero
//
// Local design decision: the AXI4-Lite slave port.
`timescale 1ns/100ps
`default_nettype none

module adc_diag_chop_delay_ctrl (
  input  wire logic                                   aclk,
  input  wire logic                                   aresetn,
  input  wire adc_ctrl_pkg::axil_req_s                axil_req,
  output var  adc_ctrl_pkg::axil_rsp_s                axil_rsp,
  output var  adc_ctrl_pkg::diag_kind_e [3:0]         chan_diag_kind,
  output var  logic [3:0]                             chan_mod_clk_delay,
  output var  logic [3:0][1:0]                        chan_chop_rate
);

  ////////////////////////////////////////////////////////////////////////////
  // registers
  logic [3:0]                      group_map_q;
  logic [3:0]                      group_map_d;
  logic [7:0]                      diag_sel_q;
  logic [7:0]                      diag_sel_d;
  logic [3:0]                      mod_delay_q;
  logic [3:0]                      mod_delay_d;
  logic [3:0]                      chop_q;
  logic [3:0]                      chop_d;

  // bus handshake state
  logic                            aw_held_q;
  logic                            w_held_q;
  logic [adc_ctrl_pkg::ADDR_W-1:0] waddr_q;
  logic [7:0]                      wbyte_q;
  logic                            wlane_q;
  logic                            awready_q;
  logic                            wready_q;
  logic                            bvalid_q;
  logic [1:0]                      bresp_q;
  logic                            arready_q;
  logic                            rvalid_q;
  logic [31:0]                     rdata_q;
  logic [1:0]                      rresp_q;

  // field views and write strobes
  logic [2:0]                      first_sel;
  logic [2:0]                      second_sel;
  logic [1:0]                      delay_pairs;
  logic [1:0]                      first_chop;
  logic [1:0]                      second_chop;
  logic                            do_write;
  logic                            wmapped;
  logic                            wstore;
  logic                            we_group_map;
  logic                            we_diag_sel;
  logic                            we_mod_delay;
  logic                            we_chop;

  assign first_sel    = diag_sel_q[adc_ctrl_pkg::FIRST_DIAG_LSB +: 3];   // [RULE1]
  assign second_sel   = diag_sel_q[adc_ctrl_pkg::SECOND_DIAG_LSB +: 3];  // [RULE1]
  assign delay_pairs  = mod_delay_q[adc_ctrl_pkg::DELAY_PAIRS_LSB +: 2]; // [RULE5]
  assign first_chop   = chop_q[adc_ctrl_pkg::FIRST_CHOP_LSB +: 2];       // [RULE7]
  assign second_chop  = chop_q[adc_ctrl_pkg::SECOND_CHOP_LSB +: 2];      // [RULE7]
  assign do_write     = aw_held_q && w_held_q && !bvalid_q;
  assign wstore       = do_write && wlane_q;
  assign we_group_map = wstore && (waddr_q == adc_ctrl_pkg::ADDR_CHAN_GROUP_MAP);
  assign we_diag_sel  = wstore && (waddr_q == adc_ctrl_pkg::ADDR_DIAG_VOLTAGE_SEL);
  assign we_mod_delay = wstore && (waddr_q == adc_ctrl_pkg::ADDR_MOD_CLK_DELAY);
  assign we_chop      = wstore && (waddr_q == adc_ctrl_pkg::ADDR_CHOP_RATE);

  always_comb begin
    unique case (waddr_q)
      adc_ctrl_pkg::ADDR_CHAN_GROUP_MAP,
      adc_ctrl_pkg::ADDR_DIAG_VOLTAGE_SEL,
      adc_ctrl_pkg::ADDR_MOD_CLK_DELAY,
      adc_ctrl_pkg::ADDR_CHOP_RATE,
      adc_ctrl_pkg::ADDR_CHAN_STATUS: wmapped = 1'b1;
      default:                        wmapped = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // write channel
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_q <= 1'b0;
      waddr_q   <= '0;
      awready_q <= 1'b0;
    end else if (axil_req.awvalid && awready_q) begin
      aw_held_q <= 1'b1;
      waddr_q   <= axil_req.awaddr;
      awready_q <= 1'b0;
    end else if (do_write) begin
      aw_held_q <= 1'b0;
    end else if (!aw_held_q && !bvalid_q) begin
      awready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held_q <= 1'b0;
      wbyte_q  <= '0;
      wlane_q  <= 1'b0;
      wready_q <= 1'b0;
    end else if (axil_req.wvalid && wready_q) begin
      w_held_q <= 1'b1;
      wbyte_q  <= axil_req.wdata[7:0];
      wlane_q  <= axil_req.wstrb[0];
      wready_q <= 1'b0;
    end else if (do_write) begin
      w_held_q <= 1'b0;
    end else if (!w_held_q && !bvalid_q) begin
      wready_q <= 1'b1;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bvalid_q <= 1'b0;
      bresp_q  <= adc_ctrl_pkg::RESP_OKAY;
    end else if (do_write) begin
      bvalid_q <= 1'b1;
      bresp_q  <= wmapped ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
    end else if (axil_req.bready && bvalid_q) begin
      bvalid_q <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register next values
  always_comb begin
    group_map_d = group_map_q;
    if (we_group_map) begin
      group_map_d = wbyte_q[3:0];
    end
  end

  always_comb begin
    diag_sel_d = diag_sel_q;
    if (we_diag_sel) begin
      diag_sel_d = wbyte_q & 8'h77;                                // [RULE10]
    end
  end

  always_comb begin
    mod_delay_d = mod_delay_q;
    if (we_mod_delay) begin
      mod_delay_d = wbyte_q[3:0];
    end
  end

  always_comb begin
    chop_d = chop_q;
    if (we_chop) begin
      chop_d = wbyte_q[3:0];
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // register storage
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      group_map_q <= adc_ctrl_pkg::RST_CHAN_GROUP_MAP;
    end else begin
      group_map_q <= group_map_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      diag_sel_q <= adc_ctrl_pkg::RST_DIAG_VOLTAGE_SEL;
    end else begin
      diag_sel_q <= diag_sel_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mod_delay_q <= adc_ctrl_pkg::RST_MOD_CLK_DELAY;              // [RULE6]
    end else begin
      mod_delay_q <= mod_delay_d;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      chop_q <= adc_ctrl_pkg::RST_CHOP_RATE;                       // [RULE8]
    end else begin
      chop_q <= chop_d;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // read channel
  logic [7:0] status_byte;
  logic [7:0] rd_byte;
  logic       rd_mapped;

  always_comb begin
    for (int c = 0; c < 4; c++) begin
      status_byte[2*c +: 2] = chan_diag_kind[c];
    end
  end

  always_comb begin
    rd_mapped = 1'b1;
    unique case (axil_req.araddr)
      adc_ctrl_pkg::ADDR_CHAN_GROUP_MAP:   rd_byte = {4'h0, group_map_q};  // [RULE10]
      adc_ctrl_pkg::ADDR_DIAG_VOLTAGE_SEL: rd_byte = diag_sel_q;
      adc_ctrl_pkg::ADDR_MOD_CLK_DELAY:    rd_byte = {4'h0, mod_delay_q};  // [RULE10]
      adc_ctrl_pkg::ADDR_CHOP_RATE:        rd_byte = {4'h0, chop_q};       // [RULE10]
      adc_ctrl_pkg::ADDR_CHAN_STATUS:      rd_byte = status_byte;
      default: begin
        rd_byte   = 8'h00;
        rd_mapped = 1'b0;
      end
    endcase
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b0;
      rdata_q   <= '0;
      rresp_q   <= adc_ctrl_pkg::RESP_OKAY;
    end else if (axil_req.arvalid && arready_q) begin
      arready_q <= 1'b0;
      rvalid_q  <= 1'b1;
      rdata_q   <= {24'h000000, rd_byte};
      rresp_q   <= rd_mapped ? adc_ctrl_pkg::RESP_OKAY : adc_ctrl_pkg::RESP_SLVERR;
    end else if (rvalid_q && axil_req.rready) begin
      rvalid_q  <= 1'b0;
    end else if (!rvalid_q) begin
      arready_q <= 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // bus outputs, one driver for the whole struct
  assign axil_rsp = '{
    awready: awready_q,
    wready:  wready_q,
    bvalid:  bvalid_q,
    bresp:   bresp_q,
    arready: arready_q,
    rvalid:  rvalid_q,
    rdata:   rdata_q,
    rresp:   rresp_q
  };

  ////////////////////////////////////////////////////////////////////////////
  // per channel outputs
  function automatic adc_ctrl_pkg::diag_kind_e decode_diag(input logic [2:0] sel);
    unique case (sel)                                              // [RULE2]
      adc_ctrl_pkg::DIAG_SEL_POS:  decode_diag = adc_ctrl_pkg::DIAG_POS;
      adc_ctrl_pkg::DIAG_SEL_NEG:  decode_diag = adc_ctrl_pkg::DIAG_NEG;
      adc_ctrl_pkg::DIAG_SEL_ZERO: decode_diag = adc_ctrl_pkg::DIAG_ZERO;
      default:                     decode_diag = adc_ctrl_pkg::DIAG_NONE; // [RULE10]
    endcase
  endfunction : decode_diag

  for (genvar c = 0; c < 4; c++) begin : g_chan
    logic in_second_group;

    assign in_second_group = group_map_q[c];                          // [RULE3]

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        chan_diag_kind[c] <= adc_ctrl_pkg::DIAG_NONE;
      end else if (in_second_group) begin
        chan_diag_kind[c] <= decode_diag(second_sel);                 // [RULE3]
      end else begin
        chan_diag_kind[c] <= decode_diag(first_sel);                  // [RULE3]
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        chan_mod_clk_delay[c] <= 1'b0;
      end else begin
        chan_mod_clk_delay[c] <= delay_pairs[c/2];                    // [RULE5]
      end
    end

    always_ff @(posedge aclk) begin
      if (!aresetn) begin
        chan_chop_rate[c] <= adc_ctrl_pkg::CHOP_DIV32;                // [RULE8]
      end else if (in_second_group) begin
        chan_chop_rate[c] <= second_chop;                             // [RULE3]
      end else begin
        chan_chop_rate[c] <= first_chop;                              // [RULE3]
      end
    end
  end

endmodule : adc_diag_chop_delay_ctrl

`default_nettype wire
